// file: bpw_host_model.sv
// Behavioural host that programs the generator over the serial link.
`timescale 1ns/10ps

module bpw_host_model (
	// Clock.
	input wire logic ref_clk_i,
	// Serial pins toward the generator.
	output logic spi_sclk_o,
	output logic spi_mosi_o,
	output logic spi_ss_n_o
);
	// The link clock stands low and the select is idle outside frames.
	initial begin
		spi_sclk_o = 1'b0;
		spi_mosi_o = 1'b0;
		spi_ss_n_o = 1'b1;
	end

	function automatic logic [15:0] duty_for(input logic [15:0] period,
		input int pct);
		return 16'((int'(period) * pct + 50) / 100);
	endfunction

	// Waits a number of system clock edges.
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// Shifts the top n bits of a frame inside one select frame.
	// Each link level is held half clocks, so the caller picks the pace.
	// select framed, MSB first
	task automatic send_bits(input logic [39:0] frame, input int n,
		input int half);
		@(posedge ref_clk_i);
		spi_ss_n_o <= 1'b0;
		hold(half);
		for (int i = 39; i > 39 - n; i--) begin
			spi_mosi_o <= frame[i];
			hold(half);
			spi_sclk_o <= 1'b1;
			hold(half);
			spi_sclk_o <= 1'b0;
		end
		hold(half);
		spi_ss_n_o <= 1'b1;
		// A released data line must not keep looking valid.
		spi_mosi_o <= ~frame[40 - n];
	endtask

	task automatic send_update(input logic [15:0] period,
		input logic [15:0] duty, input logic [7:0] mode, input int half);
		send_bits({period[7:0], period[15:8], duty[7:0], duty[15:8], mode},
			40, half);
	endtask
endmodule

// file: bpw_if.sv
// Carriers between the serial receiver, the pulse core and the top.
`timescale 1ns/10ps

interface bpw_byte_if;
	logic byte_valid;
	logic [7:0] byte_data;
	logic partial_drop;
	modport rx(output byte_valid, output byte_data, output partial_drop);
	modport sink(input byte_valid, input byte_data, input partial_drop);
endinterface

interface bpw_pwm_if;
	logic [15:0] period;
	logic [15:0] duty;
	logic fast_sel;
	logic run;
	logic level;
	modport core(input period, input duty, input fast_sel, input run,
		output level);
	modport ctrl(output period, output duty, output fast_sel, output run,
		input level);
endinterface

// file: bpw_pkg.sv
// Shared constants for the serially programmed backlight pulse generator.
package bpw_pkg;

	// System clock, 40 MHz.
	localparam logic [31:0] CLK_HZ = 32'h0262_5A00;
	// Fast counting source, 16.777612 MHz.
	localparam logic [31:0] FAST_SRC_HZ = 32'h0100_018C;
	// Slow counting source, 32.768 kHz.
	localparam logic [31:0] SLOW_SRC_HZ = 32'h0000_8000;
	// Phase increments per system clock: source rate over clock rate.
	localparam logic [31:0] FAST_INC =
		32'((64'(FAST_SRC_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [31:0] SLOW_INC =
		32'((64'(SLOW_SRC_HZ) << 32) / 64'(CLK_HZ));

	// Register byte offsets on the bus.
	localparam logic [7:0] ADDR_PERIOD = 8'h00;
	localparam logic [7:0] ADDR_DUTY = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CFG = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// Control byte fields.
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_MODE_LSB = 4;
	localparam logic [2:0] MODE_SINGLE_VAR = 3'h1;

	// Local configuration bits.
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_SUB_BIT = 1;
	localparam int CFG_MAIN_BIT = 2;
	localparam int CFG_RESYNC_BIT = 3;
	localparam int STATUS_ERR_BIT = 3;

	// Values after reset.
	localparam logic [15:0] PERIOD_RST = 16'h00A8;
	localparam logic [15:0] DUTY_RST = 16'h0086;
	localparam logic [7:0] CTRL_RST = 8'h13;
	localparam logic [2:0] CFG_RST = 3'h7;

	// Serial framing counts.
	localparam logic [2:0] LAST_BYTE_IDX = 3'h4;
	localparam logic [2:0] LAST_BIT_IDX = 3'h7;

endpackage

// file: bpw_pwm_core.sv
// Variable resolution pulse core counting ticks of a selectable source.
`timescale 1ns/10ps

module bpw_pwm_core (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Settings and level.
	bpw_pwm_if.core pwm
);

	typedef struct packed {
		logic [31:0] acc;
		logic tick;
		logic [15:0] count;
		logic [15:0] per;
		logic [15:0] duty;
		logic fast;
		logic level;
	} bpw_core_state_type;

	bpw_core_state_type r;
	bpw_core_state_type next_r;
	logic [32:0] sum;

	// Ticks come from a phase accumulator, so no second clock is needed;
	// the cost is up to one system clock of jitter per tick.
	always_comb begin
		next_r = r;
		// fast or slow source selection.
		// The source is latched with the period, so a period in progress
		// keeps its rate instead of stretching about 512-fold.
		sum = {1'b0, r.acc} +
			{1'b0, r.fast ? bpw_pkg::FAST_INC : bpw_pkg::SLOW_INC};
		next_r.acc = sum[31:0];
		next_r.tick = sum[32];
		if (r.tick) begin
			if (r.count >= r.per - 16'h0001 || r.per == 16'h0000) begin
				next_r.count = 16'h0000;
				// Settings load only at a wrap, so no period is cut short.
				next_r.per = pwm.period;
				next_r.duty = pwm.duty;
				next_r.fast = pwm.fast_sel;
			end else begin
				next_r.count = r.count + 16'h0001;
			end
		end
		next_r.level = pwm.run && r.per != 16'h0000 && r.count < r.duty;
	end

	// State register.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{acc: 32'h0000_0000, tick: 1'b0, count: 16'h0000,
				per: 16'h0000, duty: 16'h0000,
				fast: bpw_pkg::CTRL_RST[bpw_pkg::CTRL_FAST_BIT], level: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign pwm.level = r.level;

	property p_level_needs_run;
		@(posedge ref_clk_i) disable iff (rst_i)
		r.level |-> $past(pwm.run) && $past(r.count) < $past(r.duty);
	endproperty
	a_level_needs_run: assert property (p_level_needs_run)
		else $error("Output high without run or past duty.");

	property p_count_in_period;
		@(posedge ref_clk_i) disable iff (rst_i)
		r.per != 16'h0000 |-> r.count < r.per;
	endproperty
	a_count_in_period: assert property (p_count_in_period)
		else $error("Tick count left the period.");

	property p_slow_spacing;
		@(posedge ref_clk_i) disable iff (rst_i)
		r.tick && !r.fast |=> (r.fast || !r.tick) [*8];
	endproperty
	a_slow_spacing: assert property (p_slow_spacing)
		else $error("Slow ticks arrive too close together.");

	property p_fast_spacing;
		@(posedge ref_clk_i) disable iff (rst_i)
		r.tick |=> !r.tick;
	endproperty
	a_fast_spacing: assert property (p_fast_spacing)
		else $error("Ticks on consecutive clocks.");

endmodule

// file: bpw_spi_rx.sv
// Serial byte receiver: synchronised pins, MSB first, sample on rise.
`timescale 1ns/10ps

module bpw_spi_rx (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial pins.
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	input wire logic spi_ss_n_i,
	// Received bytes.
	bpw_byte_if.rx bytes
);

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] mosi_s;
		logic [2:0] ssn_s;
		logic sclk_acc;
		logic ssn_acc;
		logic [7:0] shift;
		logic [2:0] bits;
		logic valid;
		logic [7:0] data;
		logic drop;
	} bpw_rx_state_type;

	bpw_rx_state_type r;
	bpw_rx_state_type next_r;

	// A pin change counts once the second and third stages agree.
	always_comb begin
		next_r = r;
		next_r.valid = 1'b0;
		next_r.drop = 1'b0;
		next_r.sclk_s = {r.sclk_s[1:0], spi_sclk_i};
		next_r.mosi_s = {r.mosi_s[1:0], spi_mosi_i};
		next_r.ssn_s = {r.ssn_s[1:0], spi_ss_n_i};
		if (r.ssn_s[1] == r.ssn_s[2] && r.ssn_s[2] != r.ssn_acc) begin
			next_r.ssn_acc = r.ssn_s[2];
			// Select released mid-byte: the partial byte is thrown away.
			if (r.ssn_s[2] && r.bits != 3'h0) begin
				next_r.drop = 1'b1;
			end
			next_r.bits = 3'h0;
		end
		if (r.sclk_s[1] == r.sclk_s[2] && r.sclk_s[2] != r.sclk_acc) begin
			next_r.sclk_acc = r.sclk_s[2];
			if (r.sclk_s[2] && !r.ssn_acc) begin
				next_r.shift = {r.shift[6:0], r.mosi_s[2]};
				next_r.bits = r.bits + 3'h1;
				if (r.bits == bpw_pkg::LAST_BIT_IDX) begin
					next_r.valid = 1'b1;
					next_r.data = {r.shift[6:0], r.mosi_s[2]};
				end
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{sclk_s: 3'h0, mosi_s: 3'h0, ssn_s: 3'h7, sclk_acc: 1'b0,
				ssn_acc: 1'b1, shift: 8'h00, bits: 3'h0, valid: 1'b0,
				data: 8'h00, drop: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign bytes.byte_valid = r.valid;
	assign bytes.byte_data = r.data;
	assign bytes.partial_drop = r.drop;

	property p_byte_in_frame;
		@(posedge ref_clk_i) disable iff (rst_i)
		r.valid |-> !$past(r.ssn_acc) && r.bits == 3'h0;
	endproperty
	a_byte_in_frame: assert property (p_byte_in_frame)
		else $error("Byte completed outside a select frame.");

endmodule

// file: bpw_top.sv
// Top of the serially programmed backlight pulse generator.
//
// Overview of operation
// - Bytes are period low, period high, duty low, duty high, mode.
// - The period divisor is high byte over low byte, in ticks of the selected source.
// - The fifth byte becomes the pulse control byte.
// - Only the single variable resolution mode drives the output.
// - The period value sets the output period in source ticks.
// - The duty value sets how many ticks of each period are high.
// - Low rates count from the 32 kHz source instead of the fast one.
// - Rates from 100 Hz to 200 kHz and duty 1 to 100 percent work.
// - One waveform drives both display enables, each gated by its own configuration bit.
`timescale 1ns/10ps

module bpw_top (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial link from the host.
	input wire logic spi_sclk_i,
	input wire logic spi_mosi_i,
	input wire logic spi_ss_n_i,
	// Display enables.
	output logic sub_display_enable_o,
	output logic main_display_enable_o
);

	typedef struct packed {
		logic [15:0] period_divisor_reg;
		logic [15:0] duty_compare_reg;
		logic [7:0] pwm_control_reg;
		logic [2:0] cfg;
		logic [3:0][7:0] stage;
		logic [2:0] idx;
		logic frame_err;
		logic [7:0] upd_cnt;
		logic ack;
		logic [31:0] dat;
		logic sub;
		logic main;
	} bpw_top_state_type;

	bpw_top_state_type r;
	bpw_top_state_type next_r;
	logic bus_req;

	bpw_byte_if rx_bus ();
	bpw_pwm_if pwm_bus ();

	// Byte lane merge for a 16-bit register in the low half-word.
	function automatic logic [15:0] bpw_merge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			res[15:8] = dat[15:8];
		end
		return res;
	endfunction

	// Address decode for a write taking effect in this cycle.
	function automatic logic bpw_wr_hit(input logic req,
		input logic we, input logic [7:0] adr, input logic [7:0] off);
		return req && we && adr == off;
	endfunction

	// Serial receiver.
	bpw_spi_rx u_rx (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.spi_sclk_i(spi_sclk_i),
		.spi_mosi_i(spi_mosi_i),
		.spi_ss_n_i(spi_ss_n_i),
		.bytes(rx_bus.rx)
	);

	// Pulse core.
	bpw_pwm_core u_core (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pwm(pwm_bus.core)
	);

	// Settings fed to the core.
	assign pwm_bus.period = r.period_divisor_reg;
	assign pwm_bus.duty = r.duty_compare_reg;
	assign pwm_bus.fast_sel = r.pwm_control_reg[bpw_pkg::CTRL_FAST_BIT];
	assign pwm_bus.run = r.cfg[bpw_pkg::CFG_EN_BIT] &&
		r.pwm_control_reg[bpw_pkg::CTRL_MODE_LSB +: 3] ==
		bpw_pkg::MODE_SINGLE_VAR;

	// A new request is one not already answered in the previous cycle.
	assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;

	// Bus access, serial byte placement and output registers.
	always_comb begin
		next_r = r;
		next_r.ack = bus_req;
		next_r.sub = pwm_bus.level && r.cfg[bpw_pkg::CFG_SUB_BIT];
		next_r.main = pwm_bus.level && r.cfg[bpw_pkg::CFG_MAIN_BIT];
		// Read data is captured with the request; unmapped reads give zero.
		if (bus_req) begin
			unique case (wb_adr_i)
				bpw_pkg::ADDR_PERIOD: begin
					next_r.dat = {16'h0000, r.period_divisor_reg};
				end
				bpw_pkg::ADDR_DUTY: begin
					next_r.dat = {16'h0000, r.duty_compare_reg};
				end
				bpw_pkg::ADDR_CTRL: begin
					next_r.dat = {24'h00_0000, r.pwm_control_reg};
				end
				bpw_pkg::ADDR_CFG: begin
					next_r.dat = {28'h000_0000, 1'b0, r.cfg};
				end
				bpw_pkg::ADDR_STATUS: begin
					next_r.dat = {16'h0000, r.upd_cnt, 3'h0, pwm_bus.level,
						r.frame_err, r.idx};
				end
				default: begin
					next_r.dat = 32'h0000_0000;
				end
			endcase
		end
		// Software writes; unmapped writes are acknowledged and dropped.
		if (bpw_wr_hit(bus_req, wb_we_i, wb_adr_i, bpw_pkg::ADDR_PERIOD)) begin
			next_r.period_divisor_reg = bpw_merge16(r.period_divisor_reg,
				wb_dat_i, wb_sel_i);
		end
		if (bpw_wr_hit(bus_req, wb_we_i, wb_adr_i, bpw_pkg::ADDR_DUTY)) begin
			next_r.duty_compare_reg = bpw_merge16(r.duty_compare_reg,
				wb_dat_i, wb_sel_i);
		end
		if (bpw_wr_hit(bus_req, wb_we_i, wb_adr_i, bpw_pkg::ADDR_CTRL) &&
			wb_sel_i[0]) begin
			next_r.pwm_control_reg = wb_dat_i[7:0];
		end
		if (bpw_wr_hit(bus_req, wb_we_i, wb_adr_i, bpw_pkg::ADDR_CFG) &&
			wb_sel_i[0]) begin
			next_r.cfg = wb_dat_i[2:0];
			// Resync lets software recover from a lost byte.
			if (wb_dat_i[bpw_pkg::CFG_RESYNC_BIT]) begin
				next_r.idx = 3'h0;
			end
		end
		if (bpw_wr_hit(bus_req, wb_we_i, wb_adr_i, bpw_pkg::ADDR_STATUS) &&
			wb_sel_i[0] && wb_dat_i[bpw_pkg::STATUS_ERR_BIT]) begin
			next_r.frame_err = 1'b0;
		end
		if (rx_bus.byte_valid) begin
			if (r.idx == bpw_pkg::LAST_BYTE_IDX) begin
				next_r.period_divisor_reg = {r.stage[1], r.stage[0]};
				next_r.duty_compare_reg = {r.stage[3], r.stage[2]};
				next_r.pwm_control_reg = rx_bus.byte_data;
				next_r.idx = 3'h0;
				next_r.upd_cnt = r.upd_cnt + 8'h01;
			end else begin
				next_r.stage[r.idx[1:0]] = rx_bus.byte_data;
				next_r.idx = r.idx + 3'h1;
			end
		end
		// A dropped partial byte is flagged; the set beats a clear.
		if (rx_bus.partial_drop) begin
			next_r.frame_err = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{period_divisor_reg: bpw_pkg::PERIOD_RST,
				duty_compare_reg: bpw_pkg::DUTY_RST,
				pwm_control_reg: bpw_pkg::CTRL_RST, cfg: bpw_pkg::CFG_RST,
				stage: 32'h0000_0000, idx: 3'h0, frame_err: 1'b0,
				upd_cnt: 8'h00, ack: 1'b0, dat: 32'h0000_0000, sub: 1'b0,
				main: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register.
	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign sub_display_enable_o = r.sub;
	assign main_display_enable_o = r.main;

	property p_fifth_commits;
		@(posedge ref_clk_i) disable iff (rst_i)
		rx_bus.byte_valid && r.idx == 3'h4 |=>
			r.idx == 3'h0 && r.upd_cnt == $past(r.upd_cnt) + 8'h01;
	endproperty
	a_fifth_commits: assert property (p_fifth_commits)
		else $error("Fifth byte did not close the update.");

	property p_period_bytes;
		@(posedge ref_clk_i) disable iff (rst_i)
		rx_bus.byte_valid && r.idx == 3'h4 |=>
			r.period_divisor_reg == {$past(r.stage[1]), $past(r.stage[0])};
	endproperty
	a_period_bytes: assert property (p_period_bytes)
		else $error("Period not built from the first two bytes.");

	property p_control_byte;
		@(posedge ref_clk_i) disable iff (rst_i)
		rx_bus.byte_valid && r.idx == 3'h4 |=>
			r.pwm_control_reg == $past(rx_bus.byte_data) &&
			r.duty_compare_reg == {$past(r.stage[3]), $past(r.stage[2])};
	endproperty
	a_control_byte: assert property (p_control_byte)
		else $error("Control or duty not loaded from the frame.");

	property p_no_early_update;
		@(posedge ref_clk_i) disable iff (rst_i)
		rx_bus.byte_valid && r.idx < 3'h4 && !bus_req |=>
			$stable(r.period_divisor_reg) && $stable(r.pwm_control_reg);
	endproperty
	a_no_early_update: assert property (p_no_early_update)
		else $error("Settings changed before the fifth byte.");

	property p_both_follow;
		@(posedge ref_clk_i) disable iff (rst_i)
		##1 r.sub == ($past(pwm_bus.level) && $past(r.cfg[1])) &&
			r.main == ($past(pwm_bus.level) && $past(r.cfg[2]));
	endproperty
	a_both_follow: assert property (p_both_follow)
		else $error("Display enables do not follow the waveform.");

	property p_ack_single;
		@(posedge ref_clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single)
		else $error("Bus acknowledge held longer than one cycle.");

endmodule

// file: bpw_top_tb_top.sv
// Self-checking bench for the serially programmed pulse generator.
`timescale 1ns/10ps

module bpw_top_tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic spi_sclk;
	logic spi_mosi;
	logic spi_ss_n;
	logic sub_en;
	logic main_en;
	logic [31:0] rd;
	logic [7:0] cnt;
	int fail_count = 0;
	int tests_run = 0;
	int diff_count = 0;

	bpw_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spi_sclk_i(spi_sclk),
		.spi_mosi_i(spi_mosi), .spi_ss_n_i(spi_ss_n),
		.sub_display_enable_o(sub_en), .main_display_enable_o(main_en));

	bpw_host_model host_u (.ref_clk_i(ref_clk_i), .spi_sclk_o(spi_sclk),
		.spi_mosi_o(spi_mosi), .spi_ss_n_o(spi_ss_n));

	// Free-running 40 MHz clock.
	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// A wait that runs out is a mismatch and ends the run.
	task automatic timeout();
		fail_count++;
		$display("Error at %0t: wait ran out", $time);
		give_verdict();
	endtask

	// Compares a bus value.
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares a measured count with a tolerance.
	task automatic check_near(input int got, input int exp, input int tol);
		tests_run++;
		if (got > exp + tol || got < exp - tol) begin
			fail_count++;
			$display("Error at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask

	// Classic single cycle; data is taken at the edge that samples ack.
	task automatic wb_xfer(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'h3;
		do begin
			@(posedge ref_clk_i);
			n++;
			if (n > 50) timeout();
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic wb_rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb_xfer(1'b0, adr, 32'h0000_0000);
		check32(rd, exp);
	endtask

	// Polls the update count until it moves away from the old value.
	task automatic wait_update(input logic [7:0] old);
		int n;
		n = 0;
		do begin
			wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
			n++;
			if (n > 40) timeout();
		end while (rd[15:8] === old);
	endtask

	// One bounded clock step; also notes any split between the enables.
	task automatic step(inout int n);
		@(posedge ref_clk_i);
		n++;
		if (main_en !== sub_en) diff_count++;
		if (n > 30000) timeout();
	endtask

	// Measures one full high and low phase of the sub enable.
	task automatic measure(output int hi, output int lo);
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		while (sub_en !== 1'b0) step(n);
		while (sub_en !== 1'b1) step(n);
		while (sub_en === 1'b1) begin
			hi++;
			step(n);
		end
		while (sub_en !== 1'b1) begin
			lo++;
			step(n);
		end
	endtask

	// Source ticks converted into system clocks.
	function automatic int t2c(input int ticks, input logic [31:0] src);
		return $rtoi(real'(ticks) * real'(bpw_pkg::CLK_HZ) / real'(src) + 0.5);
	endfunction

	// The first phase may straddle a reload at wrap, so it is skipped.
	task automatic check_pwm(input int per, input int duty,
		input logic [31:0] src);
		int hi;
		int lo;
		measure(hi, lo);
		measure(hi, lo);
		check_near(hi, t2c(duty, src), 3);
		check_near(hi + lo, t2c(per, src), 3);
	endtask

	// Counts high cycles of both enables over a window.
	task automatic count_high(input int win, output int s, output int m);
		s = 0;
		m = 0;
		repeat (win) begin
			@(posedge ref_clk_i);
			if (sub_en === 1'b1) s++;
			if (main_en === 1'b1) m++;
		end
	endtask

	// Reset values, an unmapped place, and the default waveform.
	task automatic s_reset();
		wb_rd_chk(bpw_pkg::ADDR_PERIOD, 32'h0000_00A8);
		wb_rd_chk(bpw_pkg::ADDR_DUTY, 32'h0000_0086);
		wb_rd_chk(bpw_pkg::ADDR_CTRL, 32'h0000_0013);
		wb_rd_chk(bpw_pkg::ADDR_CFG, 32'h0000_0007);
		wb_rd_chk(8'h20, 32'h0000_0000);
		check_pwm(168, 134, bpw_pkg::FAST_SRC_HZ);
	endtask

	// Distinct bytes show that each lands by its position.
	task automatic s_fast_frame();
		wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
		cnt = rd[15:8];
		host_u.send_update(16'h0120, host_u.duty_for(16'h0120, 25),
			8'h13, 3);
		wait_update(cnt);
		check32({24'h00_0000, rd[15:8]}, {24'h00_0000, cnt + 8'h01});
		wb_rd_chk(bpw_pkg::ADDR_PERIOD, 32'h0000_0120);
		wb_rd_chk(bpw_pkg::ADDR_DUTY, 32'h0000_0048);
		wb_rd_chk(bpw_pkg::ADDR_CTRL, 32'h0000_0013);
		diff_count = 0;
		check_pwm(288, 72, bpw_pkg::FAST_SRC_HZ);
		check_near(diff_count, 0, 0);
	endtask

	// A slow host selects the 32 kHz source through the mode byte.
	task automatic s_slow_frame();
		wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
		cnt = rd[15:8];
		host_u.send_update(16'h0004, host_u.duty_for(16'h0004, 50),
			8'h11, 6);
		wait_update(cnt);
		check32({24'h00_0000, rd[15:8]}, {24'h00_0000, cnt + 8'h01});
		wb_rd_chk(bpw_pkg::ADDR_CTRL, 32'h0000_0011);
		check_pwm(4, 2, bpw_pkg::SLOW_SRC_HZ);
	endtask

	// Duty equal to period holds the output high throughout.
	task automatic s_full_duty();
		int s;
		int m;
		wb_xfer(1'b1, bpw_pkg::ADDR_CTRL, 32'h0000_0013);
		wb_xfer(1'b1, bpw_pkg::ADDR_PERIOD, 32'h0000_0040);
		wb_xfer(1'b1, bpw_pkg::ADDR_DUTY, 32'h0000_0040);
		// Values load at wrap, so the slow period still running must end.
		repeat (6000) @(posedge ref_clk_i);
		count_high(500, s, m);
		check_near(s, 500, 0);
		check_near(m, 500, 0);
	endtask

	// An unsupported mode holds low; then only the sub enable follows.
	task automatic s_mode_gate();
		int s;
		int m;
		wb_xfer(1'b1, bpw_pkg::ADDR_CTRL, 32'h0000_0023);
		repeat (400) @(posedge ref_clk_i);
		count_high(500, s, m);
		check_near(s + m, 0, 0);
		wb_xfer(1'b1, bpw_pkg::ADDR_CTRL, 32'h0000_0013);
		wb_xfer(1'b1, bpw_pkg::ADDR_DUTY, 32'h0000_0020);
		wb_xfer(1'b1, bpw_pkg::ADDR_CFG, 32'h0000_0003);
		check_pwm(64, 32, bpw_pkg::FAST_SRC_HZ);
		count_high(500, s, m);
		check_near(m, 0, 0);
		check_near(s > 0, 1, 0);
	endtask

	// A cut byte flags an error; clear and resync bring the link back.
	task automatic s_frame_err();
		wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
		cnt = rd[15:8];
		host_u.send_bits(40'hA5_0000_0000, 4, 3);
		// The select release needs the synchroniser delay to land.
		repeat (8) @(posedge ref_clk_i);
		wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
		check32(rd & 32'hFFFF_FFEF, {16'h0000, cnt, 8'h08});
		wb_xfer(1'b1, bpw_pkg::ADDR_STATUS, 32'h0000_0008);
		host_u.send_bits(40'hA5_0000_0000, 8, 3);
		repeat (8) @(posedge ref_clk_i);
		wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
		check32(rd & 32'hFFFF_FFEF, {16'h0000, cnt, 8'h01});
		wb_xfer(1'b1, bpw_pkg::ADDR_CFG, 32'h0000_000F);
		wb_xfer(1'b0, bpw_pkg::ADDR_STATUS, 32'h0000_0000);
		check32(rd & 32'hFFFF_FFEF, {16'h0000, cnt, 8'h00});
	endtask

	// Main sequence.
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		s_reset();
		s_fast_frame();
		s_slow_frame();
		s_full_duty();
		s_mode_gate();
		s_frame_err();
		give_verdict();
	end
endmodule
